// [src/mbi_pkg.sv]
`default_nettype none
package mbi_pkg;

  // ***************************************************************
  // Bus types.
  // ***************************************************************
  typedef enum logic [2:0] {
    MODE_MUX8,
    MODE_NONMUX8,
    MODE_PAGE,
    MODE_BURST,
    MODE_EPHASE
  } mbi_mode_e;

  // ***************************************************************
  // Widths and positions.
  // ***************************************************************
  localparam int ADDR_W    = 20;
  localparam int SHARED_ADDR_DATA_PORT_W    = 16;
  localparam int BYTE_W    = 8;
  localparam int EXT_W     = 4;
  localparam int EXT_LSB   = 16;
  localparam int NIB_W     = 4;
  localparam int SYNC_W    = SHARED_ADDR_DATA_PORT_W + EXT_W + BYTE_W + 4;
  localparam int SYNC_ALE  = 0;
  localparam int SYNC_C0   = 1;
  localparam int SYNC_C1   = 2;
  localparam int SYNC_C2   = 3;
  localparam int SYNC_PF   = 4;
  localparam int SYNC_PA   = SYNC_PF + BYTE_W;
  localparam int SYNC_AD   = SYNC_PA + EXT_W;

  // ***************************************************************
  // Reset values.
  // ***************************************************************
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  // Control strobes come out of reset high, which is idle for every bus but enable-phase, where high control one and zero decode as a read.
  localparam logic [SYNC_W-1:0] SYNC_RST = 32'h0000000e;

endpackage
`default_nettype wire

// [src/mbi_top.sv]
// Operation
// - Non-multiplexed bus decodes without address strobe.
// - Multiplexed bus: strobe latches shared address.
// - Drive shared port only on selected read.
// - Latched address can drive ports E, F, G.
// - Multiplexed bus takes high bits on port A.
// - Non-multiplexed: address on shared port, data port F.
// - Non-multiplexed bus takes high bits on port A.
// - Classic bus uses fetch, read, write strobes.
// - Single read strobe; A16 on port A bit 0.
// - Dual read strobes on control one, two.
// - Page hit decodes without address strobe.
// - Page mode decodes live low address bits.
// - Burst bus: A3-A0 direct, A11-A4 latched.
// - Burst keeps A19-A4 while low bits step.
// - Enable-phase host uses multiplexed 8-bit interface.
// - Control pins mapped per host type.
`timescale 1ns/1ps
`default_nettype none
module mbi_top #(
  parameter int                       MEM_AW   = 8,
  parameter logic [mbi_pkg::ADDR_W-1:0] SEL_MASK = 20'hfff00,
  parameter logic [mbi_pkg::ADDR_W-1:0] SEL_BASE = 20'h00000
) (
  // Clock and reset.
  input  wire logic                        core_clk,
  input  wire logic                        nrst,
  // Static configuration.
  input  wire mbi_pkg::mbi_mode_e          bus_mode,
  input  wire logic                        single_read,
  input  wire logic [2:0]                  addr_out_en,
  input  wire logic                        port_g_high,
  // Host control pins.
  input  wire logic                        control_input_zero,
  input  wire logic                        control_input_one,
  input  wire logic                        control_input_two,
  input  wire logic                        port_d_bit0_pin,
  // Shared address and data port.
  input  wire logic [mbi_pkg::SHARED_ADDR_DATA_PORT_W-1:0]  shared_addr_data_port_in,
  output logic      [mbi_pkg::SHARED_ADDR_DATA_PORT_W-1:0]  shared_addr_data_port_out,
  output logic      [mbi_pkg::SHARED_ADDR_DATA_PORT_W-1:0]  shared_addr_data_port_oe,
  // Port A high address and burst low address.
  input  wire logic [mbi_pkg::EXT_W-1:0]   port_a_in,
  // Port F data or address out.
  input  wire logic [mbi_pkg::BYTE_W-1:0]  port_f_in,
  output logic      [mbi_pkg::BYTE_W-1:0]  port_f_out,
  output logic      [mbi_pkg::BYTE_W-1:0]  port_f_oe,
  // Ports E and G address out.
  output logic      [mbi_pkg::BYTE_W-1:0]  port_e_out,
  output logic      [mbi_pkg::BYTE_W-1:0]  port_e_oe,
  output logic      [mbi_pkg::BYTE_W-1:0]  port_g_out,
  output logic      [mbi_pkg::BYTE_W-1:0]  port_g_oe
);

  localparam int AW = mbi_pkg::ADDR_W;
  localparam int BW = mbi_pkg::BYTE_W;
  localparam int SW = mbi_pkg::SYNC_W;

  // ***************************************************************
  // Pin synchronisers with agreement filter.
  // ***************************************************************
  logic [SW-1:0] s1, s2, s3, pin;
  logic [SW-1:0] next_pin;

  always_comb
  begin
    next_pin = (s2 & s3) | (pin & (s2 ^ s3));
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1  <= mbi_pkg::SYNC_RST;
      s2  <= mbi_pkg::SYNC_RST;
      s3  <= mbi_pkg::SYNC_RST;
      pin <= mbi_pkg::SYNC_RST;
    end
    else
    begin
      s1  <= {shared_addr_data_port_in, port_a_in, port_f_in, control_input_two,
              control_input_one, control_input_zero, port_d_bit0_pin};
      s2  <= s1;
      s3  <= s2;
      pin <= next_pin;
    end
  end

  logic [mbi_pkg::SHARED_ADDR_DATA_PORT_W-1:0] shared_addr_data_port;
  logic [mbi_pkg::EXT_W-1:0]  pa;
  logic [BW-1:0]              pf;
  logic                       ale, c0, c1, c2;

  always_comb
  begin
    shared_addr_data_port = pin[mbi_pkg::SYNC_AD +: mbi_pkg::SHARED_ADDR_DATA_PORT_W];
    pa   = pin[mbi_pkg::SYNC_PA +: mbi_pkg::EXT_W];
    pf   = pin[mbi_pkg::SYNC_PF +: BW];
    ale  = pin[mbi_pkg::SYNC_ALE];
    c0   = pin[mbi_pkg::SYNC_C0];
    c1   = pin[mbi_pkg::SYNC_C1];
    c2   = pin[mbi_pkg::SYNC_C2];
  end

  // ***************************************************************
  // Strobe decode.
  // ***************************************************************
  logic nonmux, page, burst, ephase;
  logic rd_act, wr_act;

  always_comb
  begin
    nonmux = (bus_mode == mbi_pkg::MODE_NONMUX8);
    page   = (bus_mode == mbi_pkg::MODE_PAGE);
    burst  = (bus_mode == mbi_pkg::MODE_BURST);
    ephase = (bus_mode == mbi_pkg::MODE_EPHASE);
    if (ephase)
    begin
      rd_act = c1 && c0;
      wr_act = c1 && !c0;
    end
    else
    begin
      rd_act = !c1 || (!single_read && !c2);
      wr_act = !c0;
    end
  end

  // ***************************************************************
  // Address latch and live address.
  // ***************************************************************
  logic [BW-1:0]              lat_lo, lat_hi, next_lat_lo, next_lat_hi;
  logic [mbi_pkg::EXT_W-1:0]  lat_ext, next_lat_ext;
  logic [AW-1:0]              addr;

  always_comb
  begin
    next_lat_lo  = lat_lo;
    next_lat_hi  = lat_hi;
    next_lat_ext = lat_ext;
    if (ale && !nonmux)
    begin
      next_lat_lo  = shared_addr_data_port[BW-1:0];
      next_lat_hi  = shared_addr_data_port[mbi_pkg::SHARED_ADDR_DATA_PORT_W-1:BW];
      next_lat_ext = pa;
    end
    case (bus_mode)
      mbi_pkg::MODE_NONMUX8: addr = {pa, shared_addr_data_port};
      mbi_pkg::MODE_PAGE:    addr = {lat_ext, lat_hi, shared_addr_data_port[BW-1:0]};
      mbi_pkg::MODE_BURST:   addr = {lat_hi, lat_lo, pa};
      default:               addr = {lat_ext, shared_addr_data_port[mbi_pkg::SHARED_ADDR_DATA_PORT_W-1:BW], lat_lo};
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lat_lo  <= mbi_pkg::BYTE_RST;
      lat_hi  <= mbi_pkg::BYTE_RST;
      lat_ext <= mbi_pkg::BYTE_RST[mbi_pkg::EXT_W-1:0];
    end
    else
    begin
      lat_lo  <= next_lat_lo;
      lat_hi  <= next_lat_hi;
      lat_ext <= next_lat_ext;
    end
  end

  // ***************************************************************
  // Select decode, internal memory, read and write.
  // ***************************************************************
  logic              sel;
  logic [BW-1:0]     mem [2**MEM_AW];
  logic [BW-1:0]     rdata, wdata, next_rdata, next_wdata, din;
  logic [MEM_AW-1:0] widx, next_widx;
  logic              wr_prev, wsel, next_wsel, wr_fire;
  logic [AW-1:0]     aout, next_aout;

  always_comb
  begin
    sel        = ((addr & SEL_MASK) == SEL_BASE);
    din        = nonmux ? pf : (page ? shared_addr_data_port[mbi_pkg::SHARED_ADDR_DATA_PORT_W-1:BW] : shared_addr_data_port[BW-1:0]);
    next_rdata = mem[addr[MEM_AW-1:0]];
    next_wdata = wr_act ? din : wdata;
    next_widx  = wr_act ? addr[MEM_AW-1:0] : widx;
    next_wsel  = wr_act ? sel : wsel;
    wr_fire    = wr_prev && !wr_act && wsel;
    next_aout  = addr;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata   <= mbi_pkg::BYTE_RST;
      wdata   <= mbi_pkg::BYTE_RST;
      widx    <= '0;
      wsel    <= 1'b0;
      wr_prev <= 1'b0;
      aout    <= mbi_pkg::ADDR_RST;
    end
    else
    begin
      rdata   <= next_rdata;
      wdata   <= next_wdata;
      widx    <= next_widx;
      wsel    <= next_wsel;
      wr_prev <= wr_act;
      aout    <= next_aout;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (wr_fire)
    begin
      mem[widx] <= wdata;
    end
  end

  // ***************************************************************
  // Pin drivers.
  // ***************************************************************
  logic drive;

  always_comb
  begin
    drive = rd_act && sel;
    shared_addr_data_port_out = page ? {rdata, mbi_pkg::BYTE_RST} : {mbi_pkg::BYTE_RST, rdata};
    shared_addr_data_port_oe  = '0;
    if (drive && !nonmux)
    begin
      shared_addr_data_port_oe = page ? {{BW{1'b1}}, mbi_pkg::BYTE_RST} : {mbi_pkg::BYTE_RST, {BW{1'b1}}};
    end
    port_f_out = nonmux ? rdata : aout[BW-1:0];
    port_f_oe  = nonmux ? {BW{drive}} : {BW{addr_out_en[1]}};
    port_e_out = aout[BW-1:0];
    port_e_oe  = {BW{addr_out_en[0]}};
    port_g_out = port_g_high ? aout[2*BW-1:BW] : aout[BW-1:0];
    port_g_oe  = {BW{addr_out_en[2]}};
  end

  // ***************************************************************
  // Assertions.
  // ***************************************************************
  sequence s_wr_end;
    !wr_act && $past(wr_act) && wsel;
  endsequence

  sequence s_burst_quiet;
    burst && !ale ##1 burst && !ale;
  endsequence

  a_shared_addr_data_port_drive: assert property (@(posedge core_clk) disable iff (!nrst)
    (shared_addr_data_port_oe != '0) |-> (rd_act && sel && !nonmux))
    else $error("Shared port driven outside a selected read.");

  a_portf_idle: assert property (@(posedge core_clk) disable iff (!nrst)
    (nonmux && !(rd_act && sel)) |-> (port_f_oe == '0))
    else $error("Port F driven while not accessed.");

  a_mux_latch: assert property (@(posedge core_clk) disable iff (!nrst)
    (ale && bus_mode == mbi_pkg::MODE_MUX8) |=> (lat_lo == $past(shared_addr_data_port[7:0])))
    else $error("Low address byte not latched on strobe.");

  a_nonmux_live: assert property (@(posedge core_clk) disable iff (!nrst)
    nonmux |-> (addr == {pa, shared_addr_data_port}))
    else $error("Non-multiplexed address not taken live.");

  a_page_live: assert property (@(posedge core_clk) disable iff (!nrst)
    page |-> (addr[7:0] == shared_addr_data_port[7:0]))
    else $error("Page address low byte not live.");

  a_burst_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    s_burst_quiet |-> $stable(addr[19:4]) && addr[3:0] == pa)
    else $error("Burst upper address moved without strobe.");

  a_ephase_dir: assert property (@(posedge core_clk) disable iff (!nrst)
    (ephase && c1) |-> (rd_act == c0) && (wr_act == !c0))
    else $error("Enable-phase direction decode wrong.");

  a_single_read: assert property (@(posedge core_clk) disable iff (!nrst)
    (!ephase && single_read && c1) |-> !rd_act)
    else $error("Fetch strobe read in single strobe setup.");

  a_write_commit: assert property (@(posedge core_clk) disable iff (!nrst)
    s_wr_end |=> (mem[$past(widx)] == $past(wdata)))
    else $error("Write not stored at trailing strobe edge.");

  a_addr_out_e: assert property (@(posedge core_clk) disable iff (!nrst)
    addr_out_en[0] |=> (port_e_out == $past(addr[7:0])) && port_e_oe == {8{addr_out_en[0]}})
    else $error("Port E does not show latched address.");

endmodule // mbi_top
`default_nettype wire

// [tb/mbi_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// Host processor model on the multiplexed or plain bus.
// ***************************************************************
module mbi_host (
  // Clock and bus type.
  input  wire logic               clk,
  input  wire mbi_pkg::mbi_mode_e m,
  // Pins towards the device.
  output logic                    ale,
  output logic                    c0,
  output logic                    c1,
  output logic                    c2,
  output logic [15:0]             ad,
  output logic [3:0]              pa,
  output logic [7:0]              pf,
  // Device side of the shared lines.
  input  wire logic [15:0]        ad_out,
  input  wire logic [15:0]        ad_oe,
  input  wire logic [7:0]         pf_out,
  input  wire logic [7:0]         pf_oe,
  // Resolved line levels.
  output logic [15:0]             ad_r,
  output logic [7:0]              pf_r
);
  wire logic nm = (m == mbi_pkg::MODE_NONMUX8);
  wire logic pg = (m == mbi_pkg::MODE_PAGE);
  wire logic bu = (m == mbi_pkg::MODE_BURST);
  wire logic ep = (m == mbi_pkg::MODE_EPHASE);
  assign ad_r = (ad_oe & ad_out) | (~ad_oe & ad);
  assign pf_r = (pf_oe & pf_out) | (~pf_oe & pf);
  initial
  begin
    ale = 1'h0;
    c0 = 1'h1;
    c1 = 1'h1;
    c2 = 1'h1;
    ad = 16'h0000;
    pa = 4'h0;
    pf = 8'h00;
  end
  task automatic park(input mbi_pkg::mbi_mode_e md);
    c0 = 1'h1;
    c1 = (md != mbi_pkg::MODE_EPHASE);
    c2 = 1'h1;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Kind 0 writes, 1 reads on control one, 2 reads on control two.
  task automatic acc(input int k, input bit nl, input logic [19:0] a, input logic [7:0] wd,
                     output logic [7:0] rd, output logic hit);
    c1 = !ep;
    pa = bu ? a[3:0] : a[19:16];
    ad = bu ? {a[19:12], a[11:4]} : a[15:0];
    if (!nl && !nm)
    begin
      ale = 1'h1;
      cyc(6);
      ale = 1'h0;
    end
    cyc(2);
    if (k == 0)
    begin
      if (nm) pf = wd;
      else if (pg) ad[15:8] = wd;
      else ad[7:0] = wd;
    end
    else
    begin
      pf = ~pf;
      if (pg) ad[15:8] = ~ad[15:8];
      else if (!nm) ad[7:0] = ~ad[7:0];
    end
    case (k)
      0: if (ep) {c0, c1} = 2'h1; else c0 = 1'h0;
      1: if (ep) {c0, c1} = 2'h3; else c1 = 1'h0;
      default: c2 = 1'h0;
    endcase
    cyc(8);
    rd = nm ? pf_r : (pg ? ad_r[15:8] : ad_r[7:0]);
    hit = nm ? &pf_oe : (pg ? &ad_oe[15:8] : &ad_oe[7:0]);
    c0 = 1'h1;
    c1 = !ep;
    c2 = 1'h1;
    cyc(6);
  endtask
endmodule // mbi_host
`default_nettype wire

// [tb/mcu_bus_interface_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// Self-checking bench.
// ***************************************************************
module mcu_bus_interface_bench;
  logic               core_clk, nrst, single_read, port_g_high, ale, c0, c1, c2, h;
  mbi_pkg::mbi_mode_e bus_mode;
  logic [2:0]         addr_out_en;
  logic [3:0]         pa;
  logic [15:0]        ad, ad_out, ad_oe, ad_r;
  logic [7:0]         pf, pf_out, pf_oe, pf_r, pe, pe_oe, pgo, pg_oe, rd;
  int                 err_total, n_compared;
  mbi_top DUT (.core_clk(core_clk), .nrst(nrst), .bus_mode(bus_mode), .single_read(single_read),
    .addr_out_en(addr_out_en), .port_g_high(port_g_high), .control_input_zero(c0),
    .control_input_one(c1), .control_input_two(c2), .port_d_bit0_pin(ale),
    .shared_addr_data_port_in(ad_r), .shared_addr_data_port_out(ad_out),
    .shared_addr_data_port_oe(ad_oe), .port_a_in(pa), .port_f_in(pf_r), .port_f_out(pf_out),
    .port_f_oe(pf_oe), .port_e_out(pe), .port_e_oe(pe_oe), .port_g_out(pgo), .port_g_oe(pg_oe));
  mbi_host host (.clk(core_clk), .m(bus_mode), .ale(ale), .c0(c0), .c1(c1), .c2(c2), .ad(ad),
    .pa(pa), .pf(pf), .ad_out(ad_out), .ad_oe(ad_oe), .pf_out(pf_out), .pf_oe(pf_oe),
    .ad_r(ad_r), .pf_r(pf_r));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic setm(input mbi_pkg::mbi_mode_e md, input logic sr);
    bus_mode = md;
    single_read = sr;
    host.park(md);
    host.cyc(6);
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    host.acc(0, 0, a, d, rd, h);
  endtask
  task automatic rdk(input int k, input bit nl, input logic [19:0] a, input logic [7:0] e, input logic eh);
    host.acc(k, nl, a, 8'h00, rd, h);
    chk({7'h0, h}, {7'h0, eh});
    if (eh) chk(rd, e);
  endtask
  task automatic t_mux;
    setm(mbi_pkg::MODE_MUX8, 1'h1);
    wr(20'h00010, 8'h5a);
    rdk(1, 0, 20'h00010, 8'h5a, 1'h1);
    rdk(2, 0, 20'h00010, 8'h5a, 1'h0);
    setm(mbi_pkg::MODE_MUX8, 1'h0);
    rdk(2, 0, 20'h00010, 8'h5a, 1'h1);
    wr(20'h00110, 8'ha5);
    wr(20'h10010, 8'ha5);
    rdk(1, 0, 20'h00110, 8'h00, 1'h0);
    rdk(1, 0, 20'h10010, 8'h00, 1'h0);
    rdk(1, 0, 20'h00010, 8'h5a, 1'h1);
    $display("test mux done");
  endtask
  task automatic t_aout;
    addr_out_en = 3'h7;
    rdk(1, 0, 20'h0ab34, 8'h00, 1'h0);
    chk(pe, 8'h34);
    chk(pf_out, 8'h34);
    chk(pgo, 8'hab);
    chk(pe_oe & pf_oe & pg_oe, 8'hff);
    port_g_high = 1'h0;
    host.cyc(2);
    chk(pgo, 8'h34);
    addr_out_en = 3'h0;
    $display("test address out done");
  endtask
  task automatic t_nonmux;
    setm(mbi_pkg::MODE_NONMUX8, 1'h1);
    chk(pf_oe, 8'h00);
    wr(20'h00020, 8'hc3);
    rdk(1, 0, 20'h00020, 8'hc3, 1'h1);
    rdk(1, 0, 20'h10020, 8'h00, 1'h0);
    setm(mbi_pkg::MODE_EPHASE, 1'h1);
    wr(20'h00030, 8'h3c);
    rdk(1, 0, 20'h00030, 8'h3c, 1'h1);
    $display("test plain bus and enable phase done");
  endtask
  task automatic t_burst;
    setm(mbi_pkg::MODE_MUX8, 1'h1);
    for (int i = 0; i < 16; i++) wr(20'(32'h40 + i), 8'(32'h70 + i));
    setm(mbi_pkg::MODE_BURST, 1'h1);
    rdk(1, 0, 20'h00040, 8'h70, 1'h1);
    for (int i = 1; i < 16; i++) rdk(1, 1, 20'(32'h40 + i), 8'(32'h70 + i), 1'h1);
    setm(mbi_pkg::MODE_PAGE, 1'h1);
    rdk(1, 0, 20'h00040, 8'h70, 1'h1);
    rdk(1, 1, 20'h00045, 8'h75, 1'h1);
    $display("test burst and page done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  initial
  begin
    #100000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial
  begin
    nrst = 1'h0;
    bus_mode = mbi_pkg::MODE_MUX8;
    single_read = 1'h1;
    addr_out_en = 3'h0;
    port_g_high = 1'h1;
    err_total = 0;
    n_compared = 0;
    repeat (12) @(posedge core_clk);
    #1 nrst = 1'h1;
    t_mux();
    t_aout();
    t_nonmux();
    t_burst();
    tally_and_finish();
  end
endmodule // mcu_bus_interface_bench
`default_nettype wire
